// File: dv/tb_top.sv
/* Self-checking bench for the supervision bank: defaults, refusals, action
   codes and random threshold sweeps. Assumes the host model and the checker. */
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] sense_voltage = 16'h0130;
    logic conversion_on = 1'b1;
    logic cmd_write, cmd_read, cmd_rvalid, cmd_error;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata;
    logic ov_fault, uv_fault, ov_warning, uv_warning, output_enable;
    int fails = 0;
    int n_tests = 0;
    logic [15:0] regs [5];
    logic [7:0] acts [9] = '{8'hF8, 8'h00, 8'h16, 8'h22, 8'h36, 8'hC0, 8'hD6, 8'hE2, 8'hF6};
    always #20 clk = ~clk;
    vfw_bank i_dut (.clk, .rst, .cmd_write, .cmd_read, .cmd_code, .cmd_wdata, .sense_voltage,
        .conversion_on, .cmd_rdata, .cmd_rvalid, .cmd_error, .ov_fault, .uv_fault, .ov_warning,
        .uv_warning, .output_enable);
    vfw_host i_host (.clk, .cmd_write, .cmd_read, .cmd_code, .cmd_wdata, .cmd_rdata,
        .cmd_rvalid, .cmd_error);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Expected {ov_fault, uv_fault, ov_warning, uv_warning, output_enable}; all strict
    function automatic logic [15:0] expect_status(input logic [15:0] s, input logic on);
        logic ovf;
        ovf = s > regs[0];
        return {11'h0, ovf, s < regs[4], s > regs[2], s < regs[3],
            on && !(ovf && regs[1][7:6] != 2'h0)};
    endfunction
    // Watchdog, far beyond the expected run length
    initial begin
        #(40 * 20000);
        fails++;
        report_and_stop();
    end
    initial begin
        int j;
        logic [15:0] v;
        j = $urandom(88);
        regs = '{16'h0161, 16'h00F8, 16'h0151, 16'h0114, 16'h00F5};
        repeat (20) @(posedge clk);
        v = {10'h0, cmd_rvalid, cmd_error, ov_fault, uv_fault, ov_warning, uv_warning};
        check("reset outputs", v, 16'h0000);
        check("reset enable", {15'h0, output_enable}, 16'h0000);
        rst <= 1'b0;
        // Defaults after reset; the action byte reads back zero-extended
        for (int i = 0; i < 5; i++) begin
            i_host.xfer(1'b0, 8'h40 + i[7:0], 16'h0000);
            check("default", i_host.rd_data, regs[i]);
            check("read valid", {15'h0, i_host.rd_vld}, 16'h0001);
        end
        // Codes outside the bank are refused and read as zero
        i_host.xfer(1'b0, 8'h45, 16'h0000);
        check("unknown read", {i_host.rd_err, i_host.rd_data[14:0]}, 16'h8000);
        i_host.xfer(1'b1, 8'h3F, 16'h1234);
        check("unknown write", {14'h0, i_host.rd_vld, i_host.rd_err}, 16'h0001);
        // Each supported action is kept, a random unsupported one leaves it alone
        foreach (acts[k]) begin
            v = 16'($urandom_range(0, 255));
            if (v[7:0] inside {acts}) v = 16'h0008;
            i_host.xfer(1'b1, 8'h41, {8'h00, acts[k]});
            check("action accepted", {15'h0, i_host.rd_err}, 16'h0000);
            i_host.xfer(1'b1, 8'h41, v);
            check("action refused", {15'h0, i_host.rd_err}, 16'h0001);
            i_host.xfer(1'b0, 8'h41, 16'h0000);
            check("action kept", i_host.rd_data, {8'h00, acts[k]});
        end
        regs[1] = 16'h00F6;
        // Random limits and actions; sense lands on, just above or just below a limit, or is fully random when the action is picked
        for (int n = 0; n < 150; n++) begin
            j = $urandom_range(0, 4);
            v = (j == 1) ? {8'h00, acts[$urandom_range(0, 8)]} : 16'($urandom_range(128, 512));
            i_host.xfer(1'b1, 8'h40 + j[7:0], v);
            regs[j] = v;
            i_host.xfer(1'b0, 8'h40 + j[7:0], 16'h0000);
            check("readback", i_host.rd_data, v);
            j = $urandom_range(0, 4);
            @(posedge clk);
            sense_voltage <= (j == 1) ? 16'($urandom) : regs[j] + 16'($urandom_range(0, 2)) - 1'b1;
            conversion_on <= ($urandom_range(0, 3) != 0);
            repeat (5) @(posedge clk);
            #1;
            v = {11'h0, ov_fault, uv_fault, ov_warning, uv_warning, output_enable};
            check("status", v, expect_status(sense_voltage, conversion_on));
        end
        report_and_stop();
    end
endmodule

// File: dv/vfw_bank_props.sv
/* Port checker for the output-voltage supervision bank.
   Assumes one clock, async active-high reset, bound onto vfw_bank. */
`timescale 1ns/10ps
module vfw_bank_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] sense_voltage,
    input wire logic conversion_on,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_error,
    input wire logic ov_fault,
    input wire logic uv_fault,
    input wire logic ov_warning,
    input wire logic uv_warning,
    input wire logic output_enable
);
    logic wr_act, act_ok, known, ign;
    // Decode of the command in flight
    assign wr_act = cmd_write && cmd_code == 8'h41;
    assign known = cmd_code inside {[8'h40:8'h44]};
    assign act_ok = cmd_wdata[7:0] == 8'hF8 || (cmd_wdata[7:6] inside {2'h0, 2'h3}
        && cmd_wdata[5:0] inside {6'h00, 6'h16, 6'h22, 6'h36});
    // Shadow of the armed action; faults are judged only once it has settled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ign <= 1'b0;
        end else if (wr_act && act_ok) begin
            ign <= cmd_wdata[7:6] == 2'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmd; cmd_write || cmd_read; endsequence
    sequence s_armed; (!ign && conversion_on)[*4]; endsequence
    sequence s_running; (conversion_on && (ign || !ov_fault))[*4]; endsequence
    AST_RD_ANSWER: assert property (cmd_read |=> cmd_rvalid)
        else $error("read got no answer");
    AST_BAD_CODE: assert property (s_cmd ##0 !known |=> cmd_error)
        else $error("unknown code not refused");
    AST_BAD_ACT: assert property (wr_act && !act_ok |=> cmd_error)
        else $error("bad action not refused");
    AST_GOOD_ACT: assert property (wr_act && act_ok |=> !cmd_error)
        else $error("good action refused");
    AST_ERR_CAUSE: assert property (!cmd_write && !cmd_read |=> !cmd_error)
        else $error("error without command");
    AST_OV_OFF: assert property (s_armed ##0 ov_fault |-> !output_enable)
        else $error("output kept on in fault");
    AST_RUNS: assert property (s_running ##0 $stable(ign) |-> output_enable)
        else $error("output dropped without fault");
    AST_REENABLE: assert property (s_armed ##0 $fell(ov_fault) |-> ##[0:1] output_enable)
        else $error("output not back after fault");
endmodule
bind vfw_bank vfw_bank_props i_props (.clk, .rst, .cmd_write, .cmd_read, .cmd_code, .cmd_wdata,
    .sense_voltage, .conversion_on, .cmd_rdata, .cmd_rvalid, .cmd_error, .ov_fault, .uv_fault,
    .ov_warning, .uv_warning, .output_enable);

// File: dv/vfw_host.sv
/* Command host model: one read or write per call, answer captured.
   Assumes the bank answers one edge after it takes the command. */
`timescale 1ns/10ps
module vfw_host (
    input wire logic clk,
    output logic cmd_write = 1'b0,
    output logic cmd_read = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [15:0] cmd_wdata = 16'h0000,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_error
);
    logic [15:0] rd_data;
    logic rd_err;
    logic rd_vld;
    // Strobe held one edge, then bus shows inverted words so stale data never matches
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd_write <= wr;
        cmd_read <= !wr;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_write <= 1'b0;
        cmd_read <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~data;
        // Answer stands between the two edges; read it before the bank updates
        @(posedge clk);
        rd_data = cmd_rdata;
        rd_err = cmd_error;
        rd_vld = cmd_rvalid;
    endtask
endmodule

// File: hw/vfw_bank.sv
/*
 Output-voltage supervision command bank: overvoltage fault threshold and
 action byte, warning and undervoltage thresholds, and the output control
 that the action selects.
 Assumes the command port is driven by the bus engine on clk, and that
 sense_voltage is a sampled value already in the clk domain.
*/
`timescale 1ns/10ps
`include "vfw_cfg.svh"

// Functional notes
// - Action byte 41h, three fields, resets F8h
// - F8h: disable during fault, retry indefinitely
// - Response 00 codes: ignore fault, keep converting
// - Response 11 codes: disable while fault persists
// - Threshold 42h; above raises high warning
// - High warning threshold resets to 0151h
// - Threshold 43h; below raises low warning
// - Low warning threshold resets to 0114h
// - Threshold 44h; below declares undervoltage fault
// - Undervoltage fault threshold resets to 00F5h
// - Above 40h threshold declares overvoltage fault
module vfw_bank import vfw_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] sense_voltage,
    input wire logic conversion_on,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic cmd_error,
    output logic ov_fault,
    output logic uv_fault,
    output logic ov_warning,
    output logic uv_warning,
    output logic output_enable
);
    logic [15:0] overvoltage_fault_threshold;
    logic [7:0] overvoltage_fault_action;
    logic [15:0] overvoltage_warning_threshold;
    logic [15:0] undervoltage_warning_threshold;
    logic [15:0] undervoltage_fault_threshold;
    logic ov_hit;
    logic uv_hit;
    logic ovw_hit;
    logic uvw_hit;
    vfw_action_t action;

    // ----------------------------------------
    // Code decoding
    // ----------------------------------------
    // Returns the action of a code; bad marks an unsupported code
    // F8h is tested first because its retry bits match none of the four pairs
    function automatic vfw_action_t decode_action(input logic [7:0] code, output logic bad);
        logic [1:0] rsp;
        logic [5:0] rd;
        rsp = code[`VFW_RSP_MSB:`VFW_RSP_LSB];
        rd = code[`VFW_RTY_MSB:`VFW_DLY_LSB];
        bad = 1'b0;
        decode_action = VFW_ACT_IGNORE;
        if (rsp == `VFW_RSP_DISABLE && rd == `VFW_RTYDLY_RETRY) begin
            decode_action = VFW_ACT_RETRY;
        end else if (rd == `VFW_RTYDLY_A || rd == `VFW_RTYDLY_B ||
                     rd == `VFW_RTYDLY_C || rd == `VFW_RTYDLY_D) begin
            if (rsp == `VFW_RSP_IGNORE) begin
                decode_action = VFW_ACT_IGNORE;
            end else if (rsp == `VFW_RSP_DISABLE) begin
                decode_action = VFW_ACT_DISABLE;
            end else begin
                bad = 1'b1;
            end
        end else begin
            bad = 1'b1;
        end
    endfunction

    // Thin wrappers so processes can use the decode without an output argument
    function automatic logic code_bad(input logic [7:0] code);
        logic b;
        vfw_action_t a;
        a = decode_action(code, b);
        code_bad = b;
    endfunction

    function automatic vfw_action_t code_action(input logic [7:0] code);
        logic b;
        code_action = decode_action(code, b);
    endfunction

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // The action byte is absent here; it has its own process with a veto
    // Thresholds are taken as written; range policing is left to firmware
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overvoltage_fault_threshold <= `VFW_RST_OV_FAULT_THRESHOLD;
            overvoltage_warning_threshold <= `VFW_RST_OV_WARN_THRESHOLD;
            undervoltage_warning_threshold <= `VFW_RST_UV_WARN_THRESHOLD;
            undervoltage_fault_threshold <= `VFW_RST_UV_FAULT_THRESHOLD;
        end else if (cmd_write) begin
            case (cmd_code)
                `VFW_CMD_OV_FAULT_THRESHOLD: overvoltage_fault_threshold <= cmd_wdata;
                `VFW_CMD_OV_WARN_THRESHOLD: overvoltage_warning_threshold <= cmd_wdata;
                `VFW_CMD_UV_WARN_THRESHOLD: undervoltage_warning_threshold <= cmd_wdata;
                `VFW_CMD_UV_FAULT_THRESHOLD: undervoltage_fault_threshold <= cmd_wdata;
                default: ;
            endcase
        end
    end

    // Action byte keeps its old value when the new code is unsupported
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overvoltage_fault_action <= `VFW_RST_OV_FAULT_ACTION;
        end else if (cmd_write && cmd_code == `VFW_CMD_OV_FAULT_ACTION &&
                     !code_bad(cmd_wdata[7:0])) begin
            overvoltage_fault_action <= cmd_wdata[7:0];
        end
    end

    // Error pulse for an unsupported code or an unknown command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= 1'b0;
            if (cmd_write || cmd_read) begin
                case (cmd_code)
                    `VFW_CMD_OV_FAULT_ACTION: cmd_error <= cmd_write &&
                                                           code_bad(cmd_wdata[7:0]);
                    `VFW_CMD_OV_FAULT_THRESHOLD, `VFW_CMD_OV_WARN_THRESHOLD,
                    `VFW_CMD_UV_WARN_THRESHOLD, `VFW_CMD_UV_FAULT_THRESHOLD: cmd_error <= 1'b0;
                    default: cmd_error <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    // The action byte reads in the low byte, upper byte zero
    // Unknown codes read zero so stale data never leaks with the error pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_rdata <= 16'h0000;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_read;
            if (cmd_read) begin
                case (cmd_code)
                    `VFW_CMD_OV_FAULT_THRESHOLD: cmd_rdata <= overvoltage_fault_threshold;
                    `VFW_CMD_OV_FAULT_ACTION: cmd_rdata <= {8'h00, overvoltage_fault_action};
                    `VFW_CMD_OV_WARN_THRESHOLD: cmd_rdata <= overvoltage_warning_threshold;
                    `VFW_CMD_UV_WARN_THRESHOLD: cmd_rdata <= undervoltage_warning_threshold;
                    `VFW_CMD_UV_FAULT_THRESHOLD: cmd_rdata <= undervoltage_fault_threshold;
                    default: cmd_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Comparators
    // ----------------------------------------
    // Overvoltage fault trip; also feeds the output control directly
    vfw_compare u_ov_fault (.clk(clk), .rst(rst), .sense(sense_voltage),
        .threshold(overvoltage_fault_threshold), .above(1'b1), .hit(ov_hit));
    // High warning, report only
    vfw_compare u_ov_warn (.clk(clk), .rst(rst), .sense(sense_voltage),
        .threshold(overvoltage_warning_threshold), .above(1'b1), .hit(ovw_hit));
    // Low warning, report only
    vfw_compare u_uv_warn (.clk(clk), .rst(rst), .sense(sense_voltage),
        .threshold(undervoltage_warning_threshold), .above(1'b0), .hit(uvw_hit));
    // Undervoltage fault; its response lies outside this bank
    vfw_compare u_uv_fault (.clk(clk), .rst(rst), .sense(sense_voltage),
        .threshold(undervoltage_fault_threshold), .above(1'b0), .hit(uv_hit));

    // Status levels follow the compare results one cycle later
    // The common lag keeps all four levels aligned with each other
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ov_fault <= 1'b0;
            uv_fault <= 1'b0;
            ov_warning <= 1'b0;
            uv_warning <= 1'b0;
        end else begin
            ov_fault <= ov_hit;
            uv_fault <= uv_hit;
            ov_warning <= ovw_hit;
            uv_warning <= uvw_hit;
        end
    end

    // ----------------------------------------
    // Output control
    // ----------------------------------------
    // The stored byte only ever holds supported codes, so the decode is total
    assign action = code_action(overvoltage_fault_action);

    // Warnings never enter here, so they cannot stop conversion
    // The raw compare is used so the enable drops in step with ov_fault
    // Retry and disable coincide: restart is immediate, with no hold-off delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_enable <= 1'b0;
        end else begin
            case (action)
                VFW_ACT_IGNORE: output_enable <= conversion_on;
                VFW_ACT_DISABLE: output_enable <= conversion_on && !ov_hit;
                VFW_ACT_RETRY: output_enable <= conversion_on && !ov_hit;
                // Fail safe: an undecodable action keeps the power stage off
                default: output_enable <= 1'b0;
            endcase
        end
    end
endmodule

// File: hw/vfw_cfg.svh
/*
 Constants of the output-voltage supervision command bank: command codes,
 field positions, reset values and codes.
 Assumes it is included by bare name, before any file that uses the macros.
*/
`ifndef VFW_CFG_SVH
`define VFW_CFG_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define VFW_CMD_OV_FAULT_THRESHOLD 8'h40
`define VFW_CMD_OV_FAULT_ACTION 8'h41
`define VFW_CMD_OV_WARN_THRESHOLD 8'h42
`define VFW_CMD_UV_WARN_THRESHOLD 8'h43
`define VFW_CMD_UV_FAULT_THRESHOLD 8'h44

// ----------------------------------------
// Reset values loaded when rst is asserted
// ----------------------------------------
`define VFW_RST_OV_FAULT_THRESHOLD 16'h0161
`define VFW_RST_OV_FAULT_ACTION 8'hF8
`define VFW_RST_OV_WARN_THRESHOLD 16'h0151
`define VFW_RST_UV_WARN_THRESHOLD 16'h0114
`define VFW_RST_UV_FAULT_THRESHOLD 16'h00F5

// ----------------------------------------
// Fields of the overvoltage action byte
// ----------------------------------------
`define VFW_RSP_MSB 7
`define VFW_RSP_LSB 6
`define VFW_RTY_MSB 5
`define VFW_RTY_LSB 3
`define VFW_DLY_MSB 2
`define VFW_DLY_LSB 0
`define VFW_RSP_IGNORE 2'h0
`define VFW_RSP_DISABLE 2'h3
`define VFW_RTYDLY_A 6'h00
`define VFW_RTYDLY_B 6'h16
`define VFW_RTYDLY_C 6'h22
`define VFW_RTYDLY_D 6'h36
`define VFW_RTYDLY_RETRY 6'h38

`endif

// File: hw/vfw_compare.sv
/*
 Threshold comparator for the sensed output voltage.
 Assumes sense and threshold share the same unsigned 16-bit scaling.
*/
`timescale 1ns/10ps
module vfw_compare import vfw_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] sense,
    input wire logic [15:0] threshold,
    input wire logic above,
    output logic hit
);
    // ----------------------------------------
    // Registered compare, strict inequality
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= above ? (sense > threshold) : (sense < threshold);
        end
    end
endmodule

// File: hw/vfw_pkg.sv
/*
 Types of the output-voltage supervision command bank.
 Assumes vfw_cfg.svh is compiled alongside.
*/
package vfw_pkg;
    // Action selected by the overvoltage response code
    typedef enum logic [2:0] {
        VFW_ACT_IGNORE = 3'h1,
        VFW_ACT_DISABLE = 3'h2,
        VFW_ACT_RETRY = 3'h4
    } vfw_action_t;
endpackage
